/* common/vrc_pkg.sv */
// Shared constants and types of the regulator configuration register bank
package vrc_pkg;

	// ----------------------------------------------------------------
	// Clock and watchdog timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_KHZ = 100000;
	localparam int WD_SHORT_MS = 800;
	localparam int WD_LONG_MS = 1600;
	localparam logic [27:0] WD_SHORT_CYC = 28'(WD_SHORT_MS * CLK_FREQ_KHZ);
	localparam logic [27:0] WD_LONG_CYC = 28'(WD_LONG_MS * CLK_FREQ_KHZ);

	// ----------------------------------------------------------------
	// Serial bus address and register map
	// ----------------------------------------------------------------
	// Arbitrary default bus address
	localparam logic [6:0] I2C_DEV_ADDR = 7'h20;
	localparam int NREG = 11;
	localparam int IDX_SLEW = 0;
	localparam int IDX_SOURCE_SELECT_AND_PROTECTION_ENABLES = 1;
	localparam int IDX_CONVERSION_MODE_CONTROLS = 2;
	localparam int IDX_WD = 3;
	localparam int IDX_SHDN_TH = 4;
	localparam int IDX_THERM = 5;
	localparam int IDX_CURRENT_MONITOR_OFFSET = 6;
	localparam int IDX_SET_OFS = 7;
	localparam int IDX_BOOT = 8;
	localparam int IDX_OSC = 9;
	localparam int IDX_ACN = 10;
	localparam logic [7:0] ADDR_TEMP = 8'h43;
	localparam logic [NREG-1:0][7:0] REG_ADDR = {8'h55, 8'h52, 8'h41,
		8'h27, 8'h26, 8'h22, 8'h20, 8'h1f, 8'h1e, 8'h1d, 8'h1c};
	localparam logic [NREG-1:0][7:0] REG_RST = {8'h01, 8'h20, 8'h00,
		8'h00, 8'h00, 8'h04, 8'h70, 8'h00, 8'h9c, 8'h0f, 8'h33};
	// Writable bits; all others are reserved and read as zero
	localparam logic [NREG-1:0][7:0] REG_MASK = {8'h3f, 8'h64, 8'hff,
		8'hff, 8'hff, 8'hff, 8'hf0, 8'ha0, 8'hff, 8'hff, 8'hff};

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int M1_SLEW_SRC = 7;
	localparam int M1_VSET_LATCH = 6;
	localparam int M1_PSTATE_I2C = 5;
	localparam int M1_OFS_I2C = 4;
	localparam int M1_TOCP_EN = 3;
	localparam int M1_POCP_EN = 2;
	localparam int M1_OVP_EN = 1;
	localparam int M1_UVP_EN = 0;
	localparam int M2_SPREAD = 7;
	localparam int M2_VOUT_ADC = 6;
	localparam int M2_AUTO_PH = 4;
	localparam int M2_DCM = 3;
	localparam int M2_LL = 2;
	localparam int M2_USM = 1;
	localparam int M2_TOTAL_OVERCURRENT_INDICATOR_N = 0;
	localparam int WD_EN = 7;
	localparam int WD_SOFT_RST = 6;
	localparam int WD_LONG = 5;
	localparam int TH_BH_SHUT = 7;
	localparam int TH_OTP_EN = 6;
	localparam int TH_OCP_DBL = 5;
	localparam int TH_HOT_DIS = 4;
	localparam int BOOT_SRC = 7;

	// ----------------------------------------------------------------
	// Slew code decode, mV/us, and boot code bias
	// ----------------------------------------------------------------
	localparam logic [3:0] SLEW_SPLIT = 4'h5;
	localparam logic [3:0] SLEW_HI_FIRST = 4'h6;
	localparam logic [5:0] SLEW_LO_BASE = 6'h08;
	localparam logic [5:0] SLEW_LO_STEP = 6'h02;
	localparam logic [5:0] SLEW_HI_BASE = 6'h15;
	localparam logic [5:0] SLEW_HI_STEP = 6'h03;
	localparam logic [8:0] BOOT_BIAS = 9'h00b;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		I2C_IDLE = 4'h0,
		I2C_ADDR = 4'h1,
		I2C_ACK_ADDR = 4'h2,
		I2C_REG = 4'h3,
		I2C_ACK_REG = 4'h4,
		I2C_WDATA = 4'h5,
		I2C_ACK_WDATA = 4'h6,
		I2C_RDATA = 4'h7,
		I2C_RACK = 4'h8
	} vrc_i2c_st_t;

	typedef struct packed {
		logic [7:0] setpoint;
		logic [7:0] offset;
	} vrc_host_t;

	typedef struct packed {
		logic total_oc;
		logic ov;
		logic otp;
		logic hot;
	} vrc_fault_t;

	typedef struct packed {
		logic total_oc_n;
		logic ov_n;
		logic shutdown_req_n;
		logic controller_off;
		logic hot_alert_n;
		logic temp_status;
	} vrc_status_t;

	localparam vrc_status_t STAT_RST = '{total_oc_n: 1'b1, ov_n: 1'b1,
		shutdown_req_n: 1'b1, controller_off: 1'b0, hot_alert_n: 1'b1,
		temp_status: 1'b0};

	typedef struct packed {
		logic [5:0] main_slew;
		logic [5:0] aux_slew;
		logic setpoint_latched;
		logic pstate_from_i2c;
		logic phase_from_i2c;
		logic auto_phase;
		logic discontinuous_conduction;
		logic ultrasonic_mode;
		logic pulse_skip_mode;
		logic loadline_en;
		logic spread_en;
		logic total_overcurrent_indicator_n_en;
		logic phase_ocp_en;
		logic uvp_en;
		logic ocp_double;
		logic boot_from_i2c;
		logic boot_zero;
		logic [8:0] boot_mult;
		logic [7:0] imon_offset;
		logic [3:0] shdn_threshold;
		logic [3:0] hot_threshold;
		logic [7:0] osc_ctrl;
		logic [7:0] acoustic_ctrl;
	} vrc_ctrl_t;

endpackage

/* logic/vrc_config_bank.sv */
// Regulator configuration register bank with its serial bus slave
// Summary of operation
// - Slew codes 0-5 step 2, 6-15 step 3
// - Source bit 7 picks strap or register slew
// - Bit 6 set: setpoint from latched source
// - Bit 5 set: phase count from serial bus
// - Bit 4 set: offset from bank register
// - Total overcurrent disabled holds indicator high
// - Per-phase overcurrent enable bit
// - Reported voltage: setpoint or measured reading
// - Auto phase, else serial or host phase
// - Single phase: conduction and skip mode select
// - Load line enable bit
// - Watchdog expiry restores every register default
// - Watchdog period 800 or 1600 ms
// - Soft reset restores all but watchdog register
// - Over-temperature enable and response select
// - Single-phase total overcurrent threshold doubling
// - Hot alert disable blocks alert and status
// - Signed 5 mV offset, used when selected
// - Boot voltage from resistor or register
// - Boot code zero means 0 V, else 2N-11
module vrc_config_bank #(
	parameter logic [27:0] P_WD_SHORT_CYC = vrc_pkg::WD_SHORT_CYC,
	parameter logic [27:0] P_WD_LONG_CYC = vrc_pkg::WD_LONG_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	input wire vrc_pkg::vrc_host_t i_host,
	input wire logic [7:0] i_latched_setpoint,
	input wire logic [7:0] i_strap_slew,
	input wire logic [7:0] i_measured_vout,
	input wire logic [7:0] i_temperature,
	input wire logic i_single_phase,
	input wire vrc_pkg::vrc_fault_t i_fault,
	output logic [7:0] o_setpoint,
	output logic [7:0] o_offset,
	output logic [7:0] o_reported_vout,
	output vrc_pkg::vrc_status_t o_status,
	output vrc_pkg::vrc_ctrl_t o_ctrl
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_d;
		logic sda_d;
		vrc_pkg::vrc_i2c_st_t st;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic rw;
		logic mack;
		logic drv;
		logic kick;
		logic [vrc_pkg::NREG-1:0][7:0] regs;
		logic [7:0] setpoint;
		logic [7:0] offset;
		logic [7:0] vout;
		vrc_pkg::vrc_status_t stat;
		vrc_pkg::vrc_ctrl_t ctrl;
	} vrc_bank_state_t;

	localparam vrc_bank_state_t ST_RST = '{scl_s: 2'h3, sda_s: 2'h3,
		scl_d: 1'b1, sda_d: 1'b1, st: vrc_pkg::I2C_IDLE, cnt: 4'h0,
		shreg: 8'h00, ptr: 8'h00, rw: 1'b0, mack: 1'b0, drv: 1'b0,
		kick: 1'b0, regs: vrc_pkg::REG_RST, setpoint: 8'h00,
		offset: 8'h00, vout: 8'h00, stat: vrc_pkg::STAT_RST,
		ctrl: '0};

	vrc_bank_state_t s_r;
	vrc_bank_state_t s_nxt;
	logic wd_expire;
	logic [1:0][5:0] slew_rate;

	// ----------------------------------------------------------------
	// Register read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] rd_reg(
		input logic [7:0] addr,
		input logic [vrc_pkg::NREG-1:0][7:0] regs,
		input logic [7:0] temp
	);
		logic [7:0] d;
		d = 8'h00;
		for (int i = 0; i < vrc_pkg::NREG; i++) begin
			if (addr == vrc_pkg::REG_ADDR[i]) begin
				d = regs[i] & vrc_pkg::REG_MASK[i];
			end
		end
		if (addr == vrc_pkg::ADDR_TEMP) begin
			d = temp;
		end
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Slew rate per rail
	// ----------------------------------------------------------------
	for (genvar r = 0; r < 2; r++) begin : g_slew
		logic [3:0] code;
		assign code = s_r.regs[vrc_pkg::IDX_SOURCE_SELECT_AND_PROTECTION_ENABLES][vrc_pkg::M1_SLEW_SRC]
			? s_r.regs[vrc_pkg::IDX_SLEW][4*r+3:4*r]
			: i_strap_slew[4*r+3:4*r];
		vrc_slew_decode u_dec (
			.i_code(code),
			.o_rate(slew_rate[r])
		);
	end

	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	vrc_watchdog #(
		.P_SHORT_CYC(P_WD_SHORT_CYC),
		.P_LONG_CYC(P_WD_LONG_CYC)
	) u_wd (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_enable(s_r.regs[vrc_pkg::IDX_WD][vrc_pkg::WD_EN]),
		.i_long(s_r.regs[vrc_pkg::IDX_WD][vrc_pkg::WD_LONG]),
		.i_kick(s_r.kick),
		.o_expire(wd_expire)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic soft_rst;
		logic [7:0] m1;
		logic [7:0] m2;
		logic [7:0] th;
		logic [7:0] bt;
		logic hot;
		scl = 1'b0;
		sda = 1'b0;
		s_nxt = s_r;
		soft_rst = 1'b0;
		s_nxt.kick = 1'b0;
		s_nxt.scl_s = {s_r.scl_s[0], i_scl};
		s_nxt.sda_s = {s_r.sda_s[0], i_sda};
		scl = s_r.scl_s[1];
		sda = s_r.sda_s[1];
		s_nxt.scl_d = scl;
		s_nxt.sda_d = sda;
		scl_rise = scl && !s_r.scl_d;
		scl_fall = !scl && s_r.scl_d;
		start = scl && s_r.scl_d && s_r.sda_d && !sda;
		stop = scl && s_r.scl_d && !s_r.sda_d && sda;

		// Bus protocol; start and stop override any byte in flight
		if (start) begin
			s_nxt.st = vrc_pkg::I2C_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.drv = 1'b0;
		end else if (stop) begin
			s_nxt.st = vrc_pkg::I2C_IDLE;
			s_nxt.drv = 1'b0;
		end else begin
			unique case (s_r.st)
				vrc_pkg::I2C_IDLE: begin
					s_nxt.drv = 1'b0;
				end
				vrc_pkg::I2C_ADDR, vrc_pkg::I2C_REG,
				vrc_pkg::I2C_WDATA: begin
					if (scl_rise) begin
						s_nxt.shreg = {s_r.shreg[6:0], sda};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (scl_fall && s_r.cnt == 4'h8) begin
						s_nxt.cnt = 4'h0;
						s_nxt.drv = 1'b1;
						if (s_r.st == vrc_pkg::I2C_ADDR) begin
							if (s_r.shreg[7:1] == vrc_pkg::I2C_DEV_ADDR) begin
								s_nxt.rw = s_r.shreg[0];
								s_nxt.kick = 1'b1;
								s_nxt.st = vrc_pkg::I2C_ACK_ADDR;
							end else begin
								s_nxt.drv = 1'b0;
								s_nxt.st = vrc_pkg::I2C_IDLE;
							end
						end else if (s_r.st == vrc_pkg::I2C_REG) begin
							s_nxt.ptr = s_r.shreg;
							s_nxt.st = vrc_pkg::I2C_ACK_REG;
						end else begin
							for (int i = 0; i < vrc_pkg::NREG; i++) begin
								if (s_r.ptr == vrc_pkg::REG_ADDR[i]) begin
									s_nxt.regs[i] = s_r.shreg
										& vrc_pkg::REG_MASK[i];
								end
							end
							if (s_r.ptr == vrc_pkg::REG_ADDR[vrc_pkg::IDX_WD]
								&& s_r.shreg[vrc_pkg::WD_SOFT_RST]) begin
								soft_rst = 1'b1;
							end
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.st = vrc_pkg::I2C_ACK_WDATA;
						end
					end
				end
				vrc_pkg::I2C_ACK_ADDR: begin
					if (scl_fall) begin
						if (s_r.rw) begin
							s_nxt.shreg = rd_reg(s_r.ptr, s_r.regs,
								i_temperature);
							s_nxt.drv = !s_nxt.shreg[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.st = vrc_pkg::I2C_RDATA;
						end else begin
							s_nxt.drv = 1'b0;
							s_nxt.st = vrc_pkg::I2C_REG;
						end
					end
				end
				vrc_pkg::I2C_ACK_REG, vrc_pkg::I2C_ACK_WDATA: begin
					if (scl_fall) begin
						s_nxt.drv = 1'b0;
						s_nxt.st = vrc_pkg::I2C_WDATA;
					end
				end
				vrc_pkg::I2C_RDATA: begin
					if (scl_rise) begin
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (scl_fall) begin
						if (s_r.cnt == 4'h8) begin
							s_nxt.cnt = 4'h0;
							s_nxt.drv = 1'b0;
							s_nxt.st = vrc_pkg::I2C_RACK;
						end else begin
							s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
							s_nxt.drv = !s_r.shreg[6];
						end
					end
				end
				vrc_pkg::I2C_RACK: begin
					if (scl_rise) begin
						s_nxt.mack = !sda;
					end else if (scl_fall) begin
						if (s_r.mack) begin
							s_nxt.shreg = rd_reg(s_r.ptr, s_r.regs,
								i_temperature);
							s_nxt.drv = !s_nxt.shreg[7];
							s_nxt.ptr = s_r.ptr + 8'h01;
							s_nxt.st = vrc_pkg::I2C_RDATA;
						end else begin
							s_nxt.st = vrc_pkg::I2C_IDLE;
						end
					end
				end
				default: begin
					s_nxt.drv = 1'b0;
					s_nxt.st = vrc_pkg::I2C_IDLE;
				end
			endcase
		end

		// Defaults restore; the watchdog expiry also clears itself
		if (wd_expire) begin
			s_nxt.regs = vrc_pkg::REG_RST;
		end else if (soft_rst) begin
			for (int i = 0; i < vrc_pkg::NREG; i++) begin
				if (i != vrc_pkg::IDX_WD) begin
					s_nxt.regs[i] = vrc_pkg::REG_RST[i];
				end
			end
		end

		// Registered controls derived from the bank
		m1 = s_r.regs[vrc_pkg::IDX_SOURCE_SELECT_AND_PROTECTION_ENABLES];
		m2 = s_r.regs[vrc_pkg::IDX_CONVERSION_MODE_CONTROLS];
		th = s_r.regs[vrc_pkg::IDX_THERM];
		bt = s_r.regs[vrc_pkg::IDX_BOOT];
		s_nxt.setpoint = m1[vrc_pkg::M1_VSET_LATCH]
			? i_latched_setpoint : i_host.setpoint;
		// Offset is a signed count of 5 mV steps
		s_nxt.offset = m1[vrc_pkg::M1_OFS_I2C]
			? s_r.regs[vrc_pkg::IDX_SET_OFS] : i_host.offset;
		s_nxt.vout = m2[vrc_pkg::M2_VOUT_ADC]
			? i_measured_vout : s_r.setpoint;

		s_nxt.stat.total_oc_n = !(m1[vrc_pkg::M1_TOCP_EN]
			&& i_fault.total_oc);
		s_nxt.stat.ov_n = !(m1[vrc_pkg::M1_OVP_EN] && i_fault.ov);
		s_nxt.stat.shutdown_req_n = !(th[vrc_pkg::TH_OTP_EN]
			&& !th[vrc_pkg::TH_BH_SHUT] && i_fault.otp);
		s_nxt.stat.controller_off = th[vrc_pkg::TH_OTP_EN]
			&& th[vrc_pkg::TH_BH_SHUT] && i_fault.otp;
		hot = !th[vrc_pkg::TH_HOT_DIS] && i_fault.hot;
		s_nxt.stat.hot_alert_n = !hot;
		s_nxt.stat.temp_status = hot;

		s_nxt.ctrl.main_slew = slew_rate[0];
		s_nxt.ctrl.aux_slew = slew_rate[1];
		s_nxt.ctrl.setpoint_latched = m1[vrc_pkg::M1_VSET_LATCH];
		s_nxt.ctrl.pstate_from_i2c = m1[vrc_pkg::M1_PSTATE_I2C];
		s_nxt.ctrl.auto_phase = m2[vrc_pkg::M2_AUTO_PH];
		s_nxt.ctrl.phase_from_i2c = !m2[vrc_pkg::M2_AUTO_PH]
			&& m1[vrc_pkg::M1_PSTATE_I2C];
		s_nxt.ctrl.discontinuous_conduction = i_single_phase && m2[vrc_pkg::M2_DCM];
		s_nxt.ctrl.ultrasonic_mode = i_single_phase && m2[vrc_pkg::M2_DCM]
			&& m2[vrc_pkg::M2_USM];
		s_nxt.ctrl.pulse_skip_mode = i_single_phase && m2[vrc_pkg::M2_DCM]
			&& !m2[vrc_pkg::M2_USM];
		s_nxt.ctrl.loadline_en = m2[vrc_pkg::M2_LL];
		s_nxt.ctrl.spread_en = m2[vrc_pkg::M2_SPREAD];
		s_nxt.ctrl.total_overcurrent_indicator_n_en = m2[vrc_pkg::M2_TOTAL_OVERCURRENT_INDICATOR_N];
		s_nxt.ctrl.phase_ocp_en = m1[vrc_pkg::M1_POCP_EN];
		s_nxt.ctrl.uvp_en = m1[vrc_pkg::M1_UVP_EN];
		s_nxt.ctrl.ocp_double = i_single_phase
			&& th[vrc_pkg::TH_OCP_DBL];
		s_nxt.ctrl.boot_from_i2c = bt[vrc_pkg::BOOT_SRC];
		s_nxt.ctrl.boot_zero = (bt[6:0] == 7'h00);
		// Multiplier of the setpoint step, added to the 300 mV base
		s_nxt.ctrl.boot_mult = (bt[6:0] == 7'h00) ? 9'h000
			: {1'b0, bt[6:0], 1'b0} - vrc_pkg::BOOT_BIAS;
		s_nxt.ctrl.imon_offset = s_r.regs[vrc_pkg::IDX_CURRENT_MONITOR_OFFSET];
		s_nxt.ctrl.shdn_threshold = s_r.regs[vrc_pkg::IDX_SHDN_TH][7:4];
		s_nxt.ctrl.hot_threshold = th[3:0];
		s_nxt.ctrl.osc_ctrl = s_r.regs[vrc_pkg::IDX_OSC];
		s_nxt.ctrl.acoustic_ctrl = s_r.regs[vrc_pkg::IDX_ACN];
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open-drain: the line is only ever pulled low
	assign o_sda = 1'b0;
	assign o_sda_oe_n = !s_r.drv;
	assign o_setpoint = s_r.setpoint;
	assign o_offset = s_r.offset;
	assign o_reported_vout = s_r.vout;
	assign o_status = s_r.stat;
	assign o_ctrl = s_r.ctrl;

endmodule // vrc_config_bank

/* logic/vrc_slew_decode.sv */
// Slew code to slew rate decoder
module vrc_slew_decode (
	input wire logic [3:0] i_code,
	output logic [5:0] o_rate
);

	always_comb begin
		if (i_code <= vrc_pkg::SLEW_SPLIT) begin
			o_rate = 6'(vrc_pkg::SLEW_LO_BASE
				+ vrc_pkg::SLEW_LO_STEP * {2'b00, i_code});
		end else begin
			o_rate = 6'(vrc_pkg::SLEW_HI_BASE + vrc_pkg::SLEW_HI_STEP
				* {2'b00, i_code - vrc_pkg::SLEW_HI_FIRST});
		end
	end

endmodule // vrc_slew_decode

/* logic/vrc_watchdog.sv */
// Register watchdog timer with selectable period
module vrc_watchdog #(
	parameter logic [27:0] P_SHORT_CYC = vrc_pkg::WD_SHORT_CYC,
	parameter logic [27:0] P_LONG_CYC = vrc_pkg::WD_LONG_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire logic i_long,
	input wire logic i_kick,
	output logic o_expire
);

	typedef struct packed {
		logic [27:0] cnt;
		logic expire;
	} vrc_wd_state_t;

	vrc_wd_state_t s_r;
	vrc_wd_state_t s_nxt;
	logic [27:0] limit;

	always_comb begin
		s_nxt = s_r;
		limit = i_long ? P_LONG_CYC : P_SHORT_CYC;
		s_nxt.expire = 1'b0;
		if (!i_enable || i_kick) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt >= limit - 28'h0000001) begin
			s_nxt.cnt = '0;
			s_nxt.expire = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 28'h0000001;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_expire = s_r.expire;

endmodule // vrc_watchdog

/* test/vrc_config_bank_monitor.sv */
// Port-level property checker of the configuration bank
module vrc_config_bank_monitor (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_single_phase,
	input wire logic [7:0] i_latched_setpoint,
	input wire vrc_pkg::vrc_host_t i_host,
	input wire vrc_pkg::vrc_fault_t i_fault,
	input wire logic [7:0] o_setpoint,
	input wire vrc_pkg::vrc_status_t o_status,
	input wire vrc_pkg::vrc_ctrl_t o_ctrl
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);

	// Source checks skip the first edge out of reset, still at reset data
	a_latched_setpoint: assert property (
		$past(i_nrst) && o_ctrl.setpoint_latched
		&& $stable(o_ctrl.setpoint_latched)
		|-> o_setpoint == $past(i_latched_setpoint))
		else $error("setpoint not from latched source");
	a_host_setpoint: assert property (
		$past(i_nrst) && !o_ctrl.setpoint_latched
		&& $stable(o_ctrl.setpoint_latched)
		|-> o_setpoint == $past(i_host.setpoint))
		else $error("setpoint not from host link");
	a_tocp_cause: assert property (
		!o_status.total_oc_n |-> $past(i_fault.total_oc))
		else $error("overcurrent indicator without fault");
	a_ov_cause: assert property (
		!o_status.ov_n |-> $past(i_fault.ov))
		else $error("overvoltage indicator without fault");
	a_otp_off_only: assert property (
		o_status.controller_off |-> o_status.shutdown_req_n
		&& $past(i_fault.otp))
		else $error("shutdown response not exclusive");
	a_otp_req_only: assert property (
		!o_status.shutdown_req_n |-> !o_status.controller_off
		&& $past(i_fault.otp))
		else $error("shutdown request not exclusive");
	a_hot_pair: assert property (
		o_status.temp_status ^ o_status.hot_alert_n)
		else $error("hot alert and status disagree");
	a_hot_cause: assert property (
		!o_status.hot_alert_n |-> $past(i_fault.hot))
		else $error("hot alert without hot fault");
	a_single_modes: assert property (
		o_ctrl.discontinuous_conduction || o_ctrl.ocp_double |-> $past(i_single_phase))
		else $error("single phase mode outside single phase");
	a_skip_modes: assert property (
		o_ctrl.ultrasonic_mode || o_ctrl.pulse_skip_mode |-> o_ctrl.discontinuous_conduction
		&& (o_ctrl.ultrasonic_mode ^ o_ctrl.pulse_skip_mode))
		else $error("skip mode select broken");
	a_phase_source: assert property (
		o_ctrl.phase_from_i2c |-> o_ctrl.pstate_from_i2c
		&& !o_ctrl.auto_phase)
		else $error("phase source select broken");
endmodule // vrc_config_bank_monitor

/* test/vrc_config_bank_tb_top.sv */
// Self-checking bench of the regulator configuration bank
bind vrc_config_bank vrc_config_bank_monitor mon (.i_core_clk(i_core_clk),
	.i_nrst(i_nrst), .i_single_phase(i_single_phase),
	.i_latched_setpoint(i_latched_setpoint), .i_host(i_host),
	.i_fault(i_fault), .o_setpoint(o_setpoint), .o_status(o_status),
	.o_ctrl(o_ctrl));

module vrc_config_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk, i_nrst, scl, sda_m, sda_bus, i_single_phase;
	logic o_sda, o_sda_oe_n, n;
	logic [7:0] i_latched_setpoint, i_strap_slew, i_measured_vout, q;
	logic [7:0] i_temperature, o_setpoint, o_offset, o_reported_vout;
	vrc_pkg::vrc_host_t i_host;
	vrc_pkg::vrc_fault_t i_fault;
	vrc_pkg::vrc_status_t o_status;
	vrc_pkg::vrc_ctrl_t o_ctrl;
	int errors = 0, checks_done = 0, cyc = 0;

	// Open-drain data line: low whenever either party pulls it
	assign sda_bus = sda_m & (o_sda_oe_n | o_sda);
	// Shortened watchdog periods keep the run short
	vrc_config_bank #(.P_WD_SHORT_CYC(28'hbb8), .P_WD_LONG_CYC(28'h1770))
		uut (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_scl(scl),
		.i_sda(sda_bus), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
		.i_host(i_host), .i_latched_setpoint(i_latched_setpoint),
		.i_strap_slew(i_strap_slew), .i_measured_vout(i_measured_vout),
		.i_temperature(i_temperature), .i_single_phase(i_single_phase),
		.i_fault(i_fault), .o_setpoint(o_setpoint), .o_offset(o_offset),
		.o_reported_vout(o_reported_vout), .o_status(o_status),
		.o_ctrl(o_ctrl));
	vrc_i2c_master bm (.i_clk(i_core_clk), .i_sda(sda_bus), .o_scl(scl),
		.o_sda(sda_m));

	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors++;
			end_sim();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wrc(input logic [7:0] a, input logic [7:0] d);
		bm.wr(a, d, n);
		chk(16'(n), 16'h0000);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		bm.rd(a, q, n);
		chk({7'h00, n, q}, {8'h00, e});
	endtask
	task automatic cl(input int k);
		repeat (k) @(negedge i_core_clk);
	endtask
	function automatic logic [5:0] rate(input logic [3:0] c);
		if (c <= 4'h5)
			return 6'(8 + 2 * c);
		return 6'(21 + 3 * (c - 4'h6));
	endfunction

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		i_nrst = 1'b0;
		i_host = '{setpoint: 8'h11, offset: 8'h22};
		i_latched_setpoint = 8'h33;
		i_strap_slew = 8'h6f;
		i_measured_vout = 8'h44;
		i_temperature = 8'h5a;
		i_single_phase = 1'b1;
		i_fault = '{total_oc: 1'b1, ov: 1'b1, otp: 1'b1, hot: 1'b1};
		cl(10);
		i_nrst = 1'b1;
		cl(5);
		for (int i = 0; i < vrc_pkg::NREG; i++)
			rdc(vrc_pkg::REG_ADDR[i], vrc_pkg::REG_RST[i]);
		rdc(8'h30, 8'h00);
		rdc(vrc_pkg::ADDR_TEMP, 8'h5a);
		for (int i = 0; i < vrc_pkg::NREG; i++) begin
			if (i != vrc_pkg::IDX_WD) begin
				wrc(vrc_pkg::REG_ADDR[i], 8'hff);
				rdc(vrc_pkg::REG_ADDR[i], vrc_pkg::REG_MASK[i]);
			end
		end
		chk(16'(o_reported_vout), 16'h0044);
		chk(16'({o_ctrl.boot_from_i2c, o_ctrl.boot_zero,
			o_ctrl.boot_mult}), 16'h04f3);
		chk(16'({o_status.shutdown_req_n, o_status.controller_off,
			o_status.hot_alert_n, o_status.temp_status,
			o_ctrl.ocp_double}), 16'h001d);
		chk(16'({o_ctrl.phase_from_i2c, o_ctrl.discontinuous_conduction, o_ctrl.ultrasonic_mode,
			o_ctrl.pulse_skip_mode, o_ctrl.loadline_en}), 16'h000d);
		chk({o_ctrl.osc_ctrl, o_ctrl.acoustic_ctrl},
			{vrc_pkg::REG_MASK[vrc_pkg::IDX_OSC],
			vrc_pkg::REG_MASK[vrc_pkg::IDX_ACN]});
		chk({o_ctrl.imon_offset, o_ctrl.shdn_threshold,
			o_ctrl.hot_threshold}, 16'hffff);
		for (int c = 0; c < 16; c++) begin
			wrc(8'h1c, {4'(15 - c), 4'(c)});
			chk(16'(o_ctrl.main_slew), 16'(rate(4'(c))));
			chk(16'(o_ctrl.aux_slew), 16'(rate(4'(15 - c))));
		end
		wrc(8'h1d, 8'h00);
		chk({10'h000, o_ctrl.main_slew}, 16'h0030);
		chk({10'h000, o_ctrl.aux_slew}, 16'h0015);
		chk({o_setpoint, o_offset}, 16'h1122);
		chk(16'({o_status.total_oc_n, o_status.ov_n,
			o_ctrl.phase_ocp_en, o_ctrl.uvp_en, o_ctrl.pstate_from_i2c}),
			16'h0018);
		wrc(8'h27, 8'hf6);
		wrc(8'h1d, 8'h7f);
		chk({o_setpoint, o_offset}, 16'h33f6);
		chk(16'({o_status.total_oc_n, o_status.ov_n,
			o_ctrl.phase_ocp_en, o_ctrl.uvp_en, o_ctrl.pstate_from_i2c}),
			16'h0007);
		wrc(8'h1e, 8'h08);
		chk(16'(o_reported_vout), 16'h0033);
		chk(16'({o_ctrl.phase_from_i2c, o_ctrl.discontinuous_conduction, o_ctrl.ultrasonic_mode,
			o_ctrl.pulse_skip_mode, o_ctrl.loadline_en}), 16'h001a);
		wrc(8'h22, 8'h40);
		chk(16'({o_status.shutdown_req_n, o_status.controller_off,
			o_status.hot_alert_n, o_status.temp_status,
			o_ctrl.ocp_double}), 16'h0002);
		wrc(8'h22, 8'h00);
		chk(16'({o_status.shutdown_req_n, o_status.controller_off,
			o_status.hot_alert_n, o_status.temp_status}), 16'h0009);
		i_single_phase = 1'b0;
		cl(3);
		chk(16'({o_ctrl.phase_from_i2c, o_ctrl.discontinuous_conduction, o_ctrl.ultrasonic_mode,
			o_ctrl.pulse_skip_mode}), 16'h0008);
		wrc(8'h41, 8'h05);
		chk(16'({o_ctrl.boot_from_i2c, o_ctrl.boot_zero,
			o_ctrl.boot_mult}), 16'h01ff);
		wrc(8'h41, 8'h80);
		chk(16'({o_ctrl.boot_from_i2c, o_ctrl.boot_zero}), 16'h0003);
		wrc(8'h1f, 8'h60);
		rdc(8'h1d, 8'h0f);
		rdc(8'h1f, 8'h20);
		wrc(8'h1f, 8'h80);
		wrc(8'h1d, 8'h00);
		cl(2000);
		rdc(8'h1d, 8'h00);
		cl(2000);
		rdc(8'h1d, 8'h00);
		cl(3200);
		rdc(8'h1f, 8'h00);
		rdc(8'h1d, 8'h0f);
		wrc(8'h1f, 8'ha0);
		wrc(8'h1d, 8'h00);
		cl(4500);
		rdc(8'h1d, 8'h00);
		cl(6200);
		rdc(8'h1d, 8'h0f);
		end_sim();
	end
endmodule // vrc_config_bank_tb_top

/* test/vrc_i2c_master.sv */
// Serial bus master model reaching the bank's registers
module vrc_i2c_master (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	timeunit 1ns;
	timeprecision 1ps;

	// Released lines float high on the pull-up
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic hw();
		repeat (5) @(negedge i_clk);
	endtask
	task automatic start();
		hw();
		o_sda = 1'b1;
		hw();
		o_scl = 1'b1;
		hw();
		o_sda = 1'b0;
		hw();
		o_scl = 1'b0;
	endtask
	task automatic stop();
		hw();
		o_sda = 1'b0;
		hw();
		o_scl = 1'b1;
		hw();
		o_sda = 1'b1;
		hw();
	endtask
	// Data moves only well after the clock fall, never near the rise
	task automatic xbit(input logic b, output logic r);
		hw();
		o_sda = b;
		hw();
		o_scl = 1'b1;
		hw();
		r = i_sda;
		o_scl = 1'b0;
	endtask
	task automatic xbyte(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--)
			xbit(d[i], q[i]);
		xbit(a, r);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		output logic n);
		logic [7:0] q;
		logic r0, r1, r2;
		start();
		xbyte({vrc_pkg::I2C_DEV_ADDR, 1'b0}, 1'b1, q, r0);
		xbyte(a, 1'b1, q, r1);
		xbyte(d, 1'b1, q, r2);
		n = r0 | r1 | r2;
		stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic n);
		logic [7:0] q;
		logic r0, r1, r2, r3;
		start();
		xbyte({vrc_pkg::I2C_DEV_ADDR, 1'b0}, 1'b1, q, r0);
		xbyte(a, 1'b1, q, r1);
		start();
		xbyte({vrc_pkg::I2C_DEV_ADDR, 1'b1}, 1'b1, q, r2);
		xbyte(8'hff, 1'b1, d, r3);
		// The device must have let go of the line in the closing slot
		n = r0 | r1 | r2 | !r3;
		stop();
	endtask
endmodule // vrc_i2c_master
